// [src/bus_cycle_capture.sv]
// strobe edge detector that turns bus cycles into single-cycle events
`timescale 1ns/1ns
`default_nettype none
module bus_cycle_capture (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        address_valid_n,
   input  wire logic        flash_clk,
   input  wire logic        chip_enable_n,
   input  wire logic        write_enable_n,
   input  wire logic        output_enable_n,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] wdata,
   output logic      [23:0] program_address,
   output logic      [15:0] program_data,
   output logic             write_pulse,
   output logic             read_pulse
);
   logic avd_q;
   logic clk_q;
   logic we_q;
   logic ce_q;
   logic oe_q;
   logic addr_taken;
   wire  avd_rise  = address_valid_n & ~avd_q;
   wire  clk_rise  = flash_clk & ~clk_q;
   wire  we_rise   = write_enable_n & ~we_q;
   wire  ce_rise   = chip_enable_n & ~ce_q;
   wire  addr_edge = (avd_rise | clk_rise) & ~addr_taken;
   wire  data_edge = (we_rise & ~ce_q) | (ce_rise & ~we_q);
   wire  oe_fall   = ~output_enable_n & oe_q & ~chip_enable_n;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         avd_q           <= 1'b1;
         clk_q           <= 1'b0;
         we_q            <= 1'b1;
         ce_q            <= 1'b1;
         oe_q            <= 1'b1;
         addr_taken      <= 1'b0;
         program_address <= 24'h000000;
         program_data    <= 16'h0000;
         write_pulse     <= 1'b0;
         read_pulse      <= 1'b0;
      end else begin
         avd_q       <= address_valid_n;
         clk_q       <= flash_clk;
         we_q        <= write_enable_n;
         ce_q        <= chip_enable_n;
         oe_q        <= output_enable_n;
         write_pulse <= data_edge;
         read_pulse  <= oe_fall;
         // first of the two address edges wins until the cycle closes
         if (addr_edge) begin // [R15]
            program_address <= addr;
         end
         if (data_edge | chip_enable_n) begin
            addr_taken <= 1'b0;
         end else if (addr_edge) begin
            addr_taken <= 1'b1;
         end
         // whichever strobe rises first ends the write
         if (data_edge) begin // [R16]
            program_data <= wdata;
         end
      end
   end
endmodule : bus_cycle_capture
`default_nettype wire

// [src/sector_guard_pkg.sv]
// constants for the sector protection command decoder
package sector_guard_pkg;
   localparam int          ADDR_W          = 24;
   localparam int          DATA_W          = 16;
   localparam int          SECTOR_HI       = 23;
   localparam int          SECTOR_LO       = 14;
   localparam int          SECTOR_COUNT    = 1024;
   localparam logic [11:0] UNLOCK_ADDR1    = 12'h555;
   localparam logic [11:0] UNLOCK_ADDR2    = 12'h2AA;
   localparam logic [7:0]  UNLOCK_DATA1    = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA2    = 8'h55;
   localparam logic [7:0]  CMD_PASSWORD    = 8'h60;
   localparam logic [7:0]  CMD_PERSISTENT  = 8'hC0;
   localparam logic [7:0]  CMD_FREEZE      = 8'h50;
   localparam logic [7:0]  CMD_VOLATILE    = 8'hE0;
   localparam logic [7:0]  CMD_LOCK_SET    = 8'h40;
   localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
   localparam logic [7:0]  CMD_ERASE       = 8'h80;
   localparam logic [7:0]  CMD_ERASE_ALL   = 8'h30;
   localparam logic [7:0]  CMD_EXIT        = 8'h90;
   localparam logic [7:0]  CMD_EXIT2       = 8'h00;
   localparam logic [7:0]  CMD_UNLOCK1     = 8'h25;
   localparam logic [7:0]  CMD_UNLOCK2     = 8'h03;
   localparam logic [7:0]  CMD_UNLOCK_END  = 8'h29;
   localparam logic [7:0]  VAL_GUARD_SET   = 8'h00;
   localparam logic [7:0]  VAL_GUARD_CLEAR = 8'h01;
   localparam logic [7:0]  LOCK_ADDR       = 8'h77;
   localparam int          LOCK_OTP_SECTOR = 0;
   localparam int          LOCK_PERSISTENT = 1;
   localparam int          LOCK_PASSWORD   = 2;
   localparam int          LOCK_MODE_OTP   = 3;
   localparam logic [15:0] LOCK_RESET      = 16'hFFFF;
   localparam logic [15:0] PASSWORD_RESET  = 16'hFFFF;

   typedef enum logic [3:0] {
      ST_READ       = 4'h0,
      ST_UNLOCK1    = 4'h1,
      ST_UNLOCK2    = 4'h2,
      ST_PASSWORD   = 4'h3,
      ST_PERSISTENT = 4'h4,
      ST_FREEZE     = 4'h5,
      ST_VOLATILE   = 4'h6,
      ST_LOCKREG    = 4'h7
   } mode_e;

   typedef enum logic [2:0] {
      SUB_IDLE    = 3'h0,
      SUB_PROGRAM = 3'h1,
      SUB_ERASE   = 3'h2,
      SUB_EXIT    = 3'h3,
      SUB_UNLOCK  = 3'h4
   } sub_e;
endpackage : sector_guard_pkg

// [src/sector_protection_command_decoder.sv]
// command decoder for the sector protection command sets
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: AA/555, 55/2AA, 60/555 enters password
// R2: A0 then word to 00..03, low byte
// R3: reads at 00..03 return password words
// R4: seven-write unlock with password words
// R5: 90 then 00 leaves password mode
// R6: C0 entry; A0,00 programs persistent guard
// R7: 80 then 30 erases all persistent guards
// R8: 90,00 exits; read returns persistent guard
// R9: AA, 55, 50 enters freeze mode
// R10: A0,00 sets freeze; read shows it
// R11: 90 then 00 leaves freeze mode
// R12: AA, 55, E0 enters volatile mode
// R13: A0 then 00 sets, 01 clears guard
// R14: 90 then 00 leaves volatile mode
// R15: address taken at first AVD/clock edge
// R16: data taken at first WE/CE rise
// R17: host clears one mode lock bit only
// R18: lock bits: otp sector and mode OTP
// R19: sector chosen by A23..A14 only
// R20: status data line 0 low when protected
// R21: host must exit every command set
// R22: both mode locks cleared aborts program
// R23: set commands need set entry first
// R24: unmatched writes are discarded
module sector_protection_command_decoder (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        address_valid_n,
   input  wire logic        flash_clk,
   input  wire logic        chip_enable_n,
   input  wire logic        write_enable_n,
   input  wire logic        output_enable_n,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] wdata,
   output logic      [15:0] rdata,
   output logic             rdata_valid,
   output logic      [3:0]  mode,
   output logic             password_unlocked,
   output logic             freeze,
   output logic      [15:0] protection_mode_lock
);
   logic [23:0] program_address;
   logic [15:0] program_data;
   logic        write_pulse;
   logic        read_pulse;

   bus_cycle_capture capture (
      .sys_clk         (sys_clk),
      .srst            (srst),
      .address_valid_n (address_valid_n),
      .flash_clk       (flash_clk),
      .chip_enable_n   (chip_enable_n),
      .write_enable_n  (write_enable_n),
      .output_enable_n (output_enable_n),
      .addr            (addr),
      .wdata           (wdata),
      .program_address (program_address),
      .program_data    (program_data),
      .write_pulse     (write_pulse),
      .read_pulse      (read_pulse)
   );

   sector_guard_pkg::mode_e state;
   sector_guard_pkg::sub_e  sub;
   logic [2:0]  unlock_step;
   logic [15:0] password_word [0:3];
   logic [3:0]  unlock_match;
   logic [1023:0] persistent_sector_guard;
   logic [1023:0] volatile_sector_guard;

   // command data sits in the low byte; upper byte only matters for password words and lock register writes
   wire [7:0]  cmd       = program_data[7:0];
   wire [11:0] cmd_addr  = program_address[11:0];
   wire [7:0]  low_addr  = program_address[7:0];
   wire [1:0]  word_sel  = program_address[1:0];
   wire [9:0]  wr_sector = program_address[23:14]; // [R19]
   wire [9:0]  rd_sector = addr[23:14]; // [R19]
   wire        is_unlock1 = (cmd_addr == sector_guard_pkg::UNLOCK_ADDR1);
   wire        is_unlock2 = (cmd_addr == sector_guard_pkg::UNLOCK_ADDR2);
   wire        step_aa   = is_unlock1 & (cmd == sector_guard_pkg::UNLOCK_DATA1);
   wire        step_55   = is_unlock2 & (cmd == sector_guard_pkg::UNLOCK_DATA2);
   wire        is_exit1  = (cmd == sector_guard_pkg::CMD_EXIT);
   wire        is_exit2  = (cmd == sector_guard_pkg::CMD_EXIT2);
   wire        in_set    = (state == sector_guard_pkg::ST_PASSWORD)
                         | (state == sector_guard_pkg::ST_PERSISTENT)
                         | (state == sector_guard_pkg::ST_FREEZE)
                         | (state == sector_guard_pkg::ST_VOLATILE)
                         | (state == sector_guard_pkg::ST_LOCKREG);
   wire        exit_done = write_pulse & in_set & (sub == sector_guard_pkg::SUB_EXIT)
                         & is_exit2;
   wire        word_hit  = (low_addr[7:2] == 6'h00);
   wire        both_locks = ~program_data[sector_guard_pkg::LOCK_PERSISTENT]
                          & ~program_data[sector_guard_pkg::LOCK_PASSWORD];
   wire        otp_locked = ~protection_mode_lock[sector_guard_pkg::LOCK_MODE_OTP];
   wire        freeze_blocks = freeze;

   sector_guard_pkg::mode_e next_entry;
   always_comb begin
      case (cmd)
         sector_guard_pkg::CMD_PASSWORD:   next_entry = sector_guard_pkg::ST_PASSWORD;
         sector_guard_pkg::CMD_PERSISTENT: next_entry = sector_guard_pkg::ST_PERSISTENT;
         sector_guard_pkg::CMD_FREEZE:     next_entry = sector_guard_pkg::ST_FREEZE;
         sector_guard_pkg::CMD_VOLATILE:   next_entry = sector_guard_pkg::ST_VOLATILE;
         sector_guard_pkg::CMD_LOCK_SET:   next_entry = sector_guard_pkg::ST_LOCKREG;
         default:                          next_entry = sector_guard_pkg::ST_READ;
      endcase
   end

   // mode state machine; any write that fits no step is dropped
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state        <= sector_guard_pkg::ST_READ;
         sub          <= sector_guard_pkg::SUB_IDLE;
         unlock_step  <= 3'h0;
      end else if (write_pulse) begin
         case (state)
            sector_guard_pkg::ST_READ: begin
               if (step_aa) begin
                  state <= sector_guard_pkg::ST_UNLOCK1;
               end
            end
            sector_guard_pkg::ST_UNLOCK1: begin
               state <= step_55 ? sector_guard_pkg::ST_UNLOCK2 : sector_guard_pkg::ST_READ; // [R24]
            end
            sector_guard_pkg::ST_UNLOCK2: begin
               // entry only on the third write of a valid preamble
               if (is_unlock1 && next_entry != sector_guard_pkg::ST_READ) begin // [R1] [R6] [R9] [R12] [R23]
                  state        <= next_entry;
               end else begin
                  state <= sector_guard_pkg::ST_READ; // [R24]
               end
               sub <= sector_guard_pkg::SUB_IDLE;
            end
            default: begin
               case (sub)
                  sector_guard_pkg::SUB_IDLE: begin
                     if (is_exit1) begin
                        sub <= sector_guard_pkg::SUB_EXIT;
                     end else if (cmd == sector_guard_pkg::CMD_PROGRAM) begin
                        sub <= sector_guard_pkg::SUB_PROGRAM;
                     end else if (cmd == sector_guard_pkg::CMD_ERASE
                                  && state == sector_guard_pkg::ST_PERSISTENT) begin
                        sub <= sector_guard_pkg::SUB_ERASE;
                     end else if (cmd == sector_guard_pkg::CMD_UNLOCK1 && low_addr == 8'h00
                                  && state == sector_guard_pkg::ST_PASSWORD) begin
                        sub         <= sector_guard_pkg::SUB_UNLOCK;
                        unlock_step <= 3'h0;
                     end
                  end
                  sector_guard_pkg::SUB_EXIT: begin
                     if (is_exit2) begin // [R5] [R8] [R11] [R14]
                        state <= sector_guard_pkg::ST_READ;
                     end
                     sub <= sector_guard_pkg::SUB_IDLE;
                  end
                  sector_guard_pkg::SUB_UNLOCK: begin
                     // cycles 2..7: 03, four words, 29; a misfit aborts
                     if (unlock_step == 3'h5) begin
                        sub <= sector_guard_pkg::SUB_IDLE;
                     end else if (unlock_step == 3'h0 && !(cmd == sector_guard_pkg::CMD_UNLOCK2
                                  && low_addr == 8'h00)) begin
                        sub <= sector_guard_pkg::SUB_IDLE; // [R24]
                     end else if (unlock_step != 3'h0
                                  && low_addr != {6'h00, 2'(unlock_step - 3'h1)}) begin
                        sub <= sector_guard_pkg::SUB_IDLE; // [R24]
                     end
                     unlock_step <= unlock_step + 3'h1;
                  end
                  default: begin
                     sub <= sector_guard_pkg::SUB_IDLE;
                  end
               endcase
            end
         endcase
      end
   end

   // password unlock compare, words checked in order
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         unlock_match      <= 4'h0;
         password_unlocked <= 1'b0;
      end else if (write_pulse && state == sector_guard_pkg::ST_PASSWORD
                   && sub == sector_guard_pkg::SUB_UNLOCK) begin
         if (unlock_step >= 3'h1 && unlock_step <= 3'h4) begin // [R4]
            unlock_match[2'(unlock_step - 3'h1)] <=
               (program_data == password_word[2'(unlock_step - 3'h1)]);
         end else if (unlock_step == 3'h5 && cmd == sector_guard_pkg::CMD_UNLOCK_END
                      && low_addr == 8'h00) begin
            password_unlocked <= &unlock_match; // [R4]
         end
      end
   end

   // protection bits and registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         freeze               <= 1'b0;
         protection_mode_lock <= sector_guard_pkg::LOCK_RESET;
         volatile_sector_guard <= '0;
         for (int i = 0; i < 4; i++) begin
            password_word[i] <= sector_guard_pkg::PASSWORD_RESET;
         end
      end else if (write_pulse && sub == sector_guard_pkg::SUB_PROGRAM) begin
         case (state)
            sector_guard_pkg::ST_PASSWORD: begin
               // only the low address byte picks the word
               if (word_hit && !otp_locked) begin // [R2]
                  password_word[word_sel] <= program_data;
               end
            end
            sector_guard_pkg::ST_FREEZE: begin
               if (is_exit2) begin // [R10]
                  freeze <= 1'b1;
               end
            end
            sector_guard_pkg::ST_VOLATILE: begin
               if (cmd == sector_guard_pkg::VAL_GUARD_SET) begin // [R13]
                  volatile_sector_guard[wr_sector] <= 1'b1;
               end else if (cmd == sector_guard_pkg::VAL_GUARD_CLEAR) begin // [R13]
                  volatile_sector_guard[wr_sector] <= 1'b0;
               end
            end
            sector_guard_pkg::ST_LOCKREG: begin
               // a program clearing both mode locks is dropped, mode stays persistent
               if (low_addr == sector_guard_pkg::LOCK_ADDR && !both_locks) begin // [R22] [R18]
                  protection_mode_lock <= protection_mode_lock & program_data;
               end
            end
            default: begin
               freeze <= freeze;
            end
         endcase
      end
   end

   // persistent guards: program and erase blocked while frozen
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         persistent_sector_guard <= '0;
      end else if (write_pulse && state == sector_guard_pkg::ST_PERSISTENT
                   && !freeze_blocks) begin
         if (sub == sector_guard_pkg::SUB_PROGRAM && is_exit2) begin // [R6]
            persistent_sector_guard[wr_sector] <= 1'b1;
         end else if (sub == sector_guard_pkg::SUB_ERASE
                      && cmd == sector_guard_pkg::CMD_ERASE_ALL) begin // [R7]
            persistent_sector_guard <= '0;
         end
      end
   end

   // read answers: in guard and freeze reads data line 0 low means protected
   wire [15:0] pw_read  = password_word[addr[1:0]];
   wire        pw_rd_ok = (addr[23:2] == 22'h000000);
   logic [15:0] next_rdata;
   always_comb begin
      next_rdata = 16'hFFFF;
      case (state)
         sector_guard_pkg::ST_PASSWORD:
            next_rdata = pw_rd_ok ? pw_read : 16'hFFFF; // [R3]
         sector_guard_pkg::ST_PERSISTENT:
            next_rdata = {15'h0000, ~persistent_sector_guard[rd_sector]}; // [R8] [R20]
         sector_guard_pkg::ST_FREEZE:
            next_rdata = {15'h0000, ~freeze}; // [R10] [R20]
         sector_guard_pkg::ST_VOLATILE:
            next_rdata = {15'h0000, ~volatile_sector_guard[rd_sector]}; // [R13] [R20]
         sector_guard_pkg::ST_LOCKREG:
            next_rdata = protection_mode_lock;
         default:
            next_rdata = 16'hFFFF;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata       <= 16'hFFFF;
         rdata_valid <= 1'b0;
         mode        <= 4'h0;
      end else begin
         rdata_valid <= read_pulse & in_set;
         mode        <= state;
         if (read_pulse) begin
            rdata <= next_rdata;
         end
      end
   end

   password_load_a: assert property (@(posedge sys_clk) disable iff (srst) // [R2]
      write_pulse && state == sector_guard_pkg::ST_PASSWORD
         && sub == sector_guard_pkg::SUB_PROGRAM && word_hit && !otp_locked
         |=> password_word[$past(word_sel)] == $past(program_data))
      else $error("password word not loaded");

   sequence preamble_s;
      write_pulse && state == sector_guard_pkg::ST_UNLOCK2 && is_unlock1
         && cmd == sector_guard_pkg::CMD_VOLATILE;
   endsequence

   volatile_entry_a: assert property (@(posedge sys_clk) disable iff (srst) // [R12]
      preamble_s |=> state == sector_guard_pkg::ST_VOLATILE)
      else $error("volatile entry missed");

   password_entry_a: assert property (@(posedge sys_clk) disable iff (srst) // [R1]
      write_pulse && state == sector_guard_pkg::ST_UNLOCK2 && is_unlock1
         && cmd == sector_guard_pkg::CMD_PASSWORD |=> state == sector_guard_pkg::ST_PASSWORD)
      else $error("password entry missed");

   set_exit_a: assert property (@(posedge sys_clk) disable iff (srst) // [R5]
      exit_done |=> state == sector_guard_pkg::ST_READ ##1 mode == 4'h0)
      else $error("exit did not return to read");

   freeze_set_a: assert property (@(posedge sys_clk) disable iff (srst) // [R10]
      $rose(freeze) |-> $past(state) == sector_guard_pkg::ST_FREEZE)
      else $error("freeze set outside freeze mode");

   freeze_sticky_a: assert property (@(posedge sys_clk) disable iff (srst) // [R10]
      freeze |=> freeze)
      else $error("freeze bit dropped");

   guard_status_a: assert property (@(posedge sys_clk) disable iff (srst) // [R20]
      read_pulse && state == sector_guard_pkg::ST_VOLATILE
         && volatile_sector_guard[rd_sector] |=> rdata[0] == 1'b0)
      else $error("protected sector read high");

   no_entry_in_read_a: assert property (@(posedge sys_clk) disable iff (srst) // [R23]
      state == sector_guard_pkg::ST_READ |=> !(state == sector_guard_pkg::ST_PASSWORD
         || state == sector_guard_pkg::ST_VOLATILE))
      else $error("set entered without preamble");

   lock_abort_a: assert property (@(posedge sys_clk) disable iff (srst) // [R22]
      write_pulse && state == sector_guard_pkg::ST_LOCKREG
         && sub == sector_guard_pkg::SUB_PROGRAM && both_locks
         |=> $stable(protection_mode_lock))
      else $error("both mode locks taken");

   erase_all_a: assert property (@(posedge sys_clk) disable iff (srst) // [R7]
      write_pulse && state == sector_guard_pkg::ST_PERSISTENT && !freeze
         && sub == sector_guard_pkg::SUB_ERASE && cmd == sector_guard_pkg::CMD_ERASE_ALL
         |=> persistent_sector_guard == '0)
      else $error("erase all left guards set");
endmodule : sector_protection_command_decoder
`default_nettype wire

// [tb/host_bus_model.sv]
// host memory controller model issuing asynchronous bus cycles
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
   input  wire logic        sys_clk,
   output logic             address_valid_n,
   output logic             flash_clk,
   output logic             chip_enable_n,
   output logic             write_enable_n,
   output logic             output_enable_n,
   output logic      [23:0] addr,
   output logic      [15:0] wdata
);
   // no burst traffic; the host clock idles low and pulses once only in cycles driven with ck set
   initial begin
      address_valid_n = 1'b1;
      flash_clk       = 1'b0;
      chip_enable_n   = 1'b1;
      write_enable_n  = 1'b1;
      output_enable_n = 1'b1;
      addr            = 24'h000000;
      wdata           = 16'h0000;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : step
   // strobe edges 3 clocks apart, the decoder samples them as levels
   task automatic cyc(input logic [23:0] a, input logic [15:0] d, input logic wr,
                      input logic ck);
      step(1);
      addr            <= a;
      wdata           <= d;
      chip_enable_n   <= 1'b0;
      address_valid_n <= 1'b0;
      step(3);
      if (ck) begin
         flash_clk <= 1'b1; // clock edge comes first and must win
         step(3);
         flash_clk <= 1'b0;
         addr      <= ~a; // a late strobe capture would take this wrong address
      end
      address_valid_n <= 1'b1; // address taken on strobe rise when no clock edge came first
      step(3);
      write_enable_n  <= ~wr;
      output_enable_n <= wr;
      step(3);
      write_enable_n  <= 1'b1; // data taken on write strobe rise
      output_enable_n <= 1'b1;
      step(3);
      chip_enable_n   <= 1'b1;
      // released bus shows the inverse so no stale value can pass
      addr            <= ~a;
      wdata           <= ~d;
      step(3);
   endtask : cyc
endmodule : host_bus_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the sector protection command decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        sys_clk, srst, address_valid_n, flash_clk, chip_enable_n;
   logic        write_enable_n, output_enable_n, rdata_valid, password_unlocked, freeze;
   logic [23:0] addr, sec;
   logic [15:0] wdata, rdata, protection_mode_lock;
   logic [15:0] pw [4];
   logic [15:0] exp_q [$];
   logic [15:0] msk_q [$];
   logic [3:0]  mode;
   logic [31:0] seed = 32'hDFA6CB7C;
   int          failures, cmp_count;
   host_bus_model host (.sys_clk, .address_valid_n, .flash_clk, .chip_enable_n,
      .write_enable_n, .output_enable_n, .addr, .wdata);
   sector_protection_command_decoder dut (.sys_clk, .srst, .address_valid_n, .flash_clk,
      .chip_enable_n, .write_enable_n, .output_enable_n, .addr, .wdata, .rdata,
      .rdata_valid, .mode, .password_unlocked, .freeze, .protection_mode_lock);
   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      host.cyc(a, d, 1'b1, 1'b0);
   endtask : wr
   task automatic wrc(input logic [23:0] a, input logic [15:0] d);
      host.cyc(a, d, 1'b1, 1'b1);
   endtask : wrc
   task automatic rd(input logic [23:0] a, input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      host.cyc(a, 16'h0000, 1'b0, 1'b0);
   endtask : rd
   task automatic pre(input logic [7:0] c);
      wr(24'h000555, 16'h00AA);
      wr(24'h0002AA, 16'h0055);
      wr({sec[23:20], 20'h00555}, {8'h00, c});
   endtask : pre
   task automatic leave();
      wr(rnd(), 16'h0090);
      wr(rnd(), 16'h0000);
   endtask : leave
   task automatic print_verdict();
      if (failures == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // read answers are matched in order against the notes of the driver
   always @(posedge sys_clk) begin
      if (rdata_valid === 1'b1) begin
         if (exp_q.size() == 0)
            cmp(rdata, ~rdata);
         else
            cmp(rdata & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      print_verdict();
   end
   initial begin
      srst = 1'b1;
      sec  = rnd();
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      cmp(protection_mode_lock, 16'hFFFF);
      wr(24'h000123, 16'h00A5);
      pre(8'h12);
      cmp({12'h000, mode}, 16'h0000);
      pre(8'h60);
      cmp({12'h000, mode}, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         pw[i] = rnd();
         wr(rnd(), 16'h00A0);
         wr({16'(rnd()), i[7:0]}, pw[i]);
      end
      for (int i = 0; i < 4; i++) rd(i, pw[i], 16'hFFFF);
      wr(24'h000000, 16'h0025);
      wr(24'h000000, 16'h0003);
      for (int i = 0; i < 4; i++) wr({16'(rnd()), i[7:0]}, pw[i]);
      wr(24'h000000, 16'h0029);
      cmp({15'h0000, password_unlocked}, 16'h0001);
      leave();
      cmp({12'h000, mode}, 16'h0000);
      pre(8'hC0);
      cmp({12'h000, mode}, 16'h0004);
      rd(sec, 16'h0001, 16'h0001);
      wr(rnd(), 16'h00A0);
      wr(sec, 16'h0000);
      rd({sec[23:14], 14'(rnd())}, 16'h0000, 16'h0001);
      wr(rnd(), 16'h0080);
      wr(rnd(), 16'h0030);
      rd(sec, 16'h0001, 16'h0001);
      leave();
      cmp({12'h000, mode}, 16'h0000);
      pre(8'h50);
      cmp({12'h000, mode}, 16'h0005);
      rd(rnd(), 16'h0001, 16'h0001);
      wr(rnd(), 16'h00A0);
      wr(rnd(), 16'h0000);
      cmp({15'h0000, freeze}, 16'h0001);
      rd(rnd(), 16'h0000, 16'h0001);
      leave();
      cmp({12'h000, mode}, 16'h0000);
      // with freeze set a persistent program must be refused
      pre(8'hC0);
      wr(rnd(), 16'h00A0);
      wr(sec, 16'h0000);
      rd(sec, 16'h0001, 16'h0001);
      leave();
      pre(8'hE0);
      cmp({12'h000, mode}, 16'h0006);
      for (int v = 0; v < 2; v++) begin
         wr(rnd(), 16'h00A0);
         wrc(sec, v[15:0]);
         rd(sec, v[15:0], 16'h0001);
      end
      leave();
      cmp({12'h000, mode}, 16'h0000);
      pre(8'h40);
      wr(rnd(), 16'h00A0);
      wr(24'h000077, 16'hFFF9);
      cmp(protection_mode_lock, 16'hFFFF);
      wr(rnd(), 16'h00A0);
      wr(24'h000077, 16'hFFFD);
      cmp(protection_mode_lock, 16'hFFFD);
      rd(rnd(), 16'hFFFD, 16'hFFFF);
      leave();
      repeat (10) @(posedge sys_clk);
      cmp(16'(exp_q.size()), 16'h0000);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
